// *** cbr_pkg.sv ***
// Package with the register map, field positions and reset values of the bridge config bank.
package cbr_pkg;

    // Printed offsets are register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_IO1_BASE_LOWER = 8'h34;
    localparam logic [7:0] IDX_IO1_BASE_UPPER = 8'h36;
    localparam logic [7:0] IDX_IO1_LIMIT_LOWER = 8'h38;
    localparam logic [7:0] IDX_IO1_LIMIT_UPPER = 8'h3A;
    localparam logic [7:0] IDX_IRQ_LINE = 8'h3C;
    localparam logic [7:0] IDX_IRQ_PIN = 8'h3D;
    localparam logic [7:0] IDX_BRIDGE_CTRL = 8'h3E;
    localparam logic [7:0] IDX_BOARD_MAKER = 8'h40;
    localparam logic [7:0] IDX_BOARD_VARIANT = 8'h42;
    localparam logic [7:0] IDX_LEGACY_BASE = 8'h44;

    // Reset values.
    localparam logic [15:0] RST_IO1_BASE_LOWER = 16'h0000;
    localparam logic [15:0] RST_IO1_BASE_UPPER = 16'h0000;
    localparam logic [15:0] RST_IO1_LIMIT_LOWER = 16'h0000;
    localparam logic [7:0] RST_IRQ_LINE = 8'h00;
    localparam logic [15:0] RST_BRIDGE_CTRL = 16'h0340;
    localparam logic [31:0] RST_LEGACY_BASE = 32'h0000_0000;

    // Interrupt pin codes.
    localparam logic [7:0] IRQ_PIN_SOCKET_A = 8'h01;
    localparam logic [7:0] IRQ_PIN_SOCKET_B = 8'h02;

    // Bridge control fields.
    localparam int BC_PARITY_EN = 0;
    localparam int BC_SERR_EN = 1;
    localparam int BC_ALIAS_BLOCK = 2;
    localparam int BC_MABORT_MODE = 5;
    localparam int BC_CARD_RESET = 6;
    localparam logic [15:0] BC_WRITE_MASK = 16'h0067;
    localparam logic [15:0] BC_FIXED_ONES = 16'h0300;

    // Legacy port base fields.
    localparam logic [31:0] LEG_BASE_MASK = 32'hFFFF_F000;
    localparam logic [31:0] LEG_IO_SPACE = 32'h0000_0001;
    localparam logic [31:0] LEG_FIXED_INDEX = 32'h0000_03E0;
    localparam logic [31:0] LEG_DATA_OFS = 32'h0000_0001;
    localparam logic [31:0] LEG_BAD2_OFS = 32'h0000_0002;
    localparam logic [31:0] LEG_BAD3_OFS = 32'h0000_0003;

    // IO window lower base: bits 1:0 read as zero.
    localparam logic [15:0] IO_BASE_LOWER_MASK = 16'hFFFC;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Narrowest bus address that reaches every register word.
    localparam int MIN_ADDR_W = 9;

endpackage

// *** cbr_config_regs.sv ***
// Configuration register bank of the bridge function with IO window and legacy port decode.
//
// Overview of operation
// RULE1 - Upper IO window base is 16-bit read/write, resets to zero.
// RULE2 - IO window limit compares only address bits 15 to 12.
// RULE3 - Upper half of the IO limit is unused and reads zero.
// RULE4 - Interrupt line register stores software's level, resets zero, no effect.
// RULE5 - Interrupt pin reads 01h for socket A, 02h for socket B.
// RULE6 - Bridge control bits 15:10, 7 and 4:3 read zero.
// RULE7 - Bridge control bits 9 and 8 are fixed at one.
// RULE8 - Card reset output follows bridge control bit 6; reset value 0340h.
// RULE9 - Mode zero master abort returns all ones and discards write data.
// RULE10 - Mode one master abort with pending origin gives target abort.
// RULE11 - Mode one abort on completed posted write raises system error if enabled.
// RULE12 - Alias block stops PCI-to-card IO to upper 768 bytes below 64 KB.
// RULE13 - Alias block never applies to IO coming from the card.
// RULE14 - Card system error reaches PCI only while bridge control bit 1 set.
// RULE15 - Card parity errors are reported only while bridge control bit 0 set.
// RULE16 - Subsystem vendor and subsystem identifier words always read zero.
// RULE17 - Software sets legacy port base bits 31 to 12.
// RULE18 - Index port at legacy base, data port at base plus one.
// RULE19 - Host must not access legacy base plus two or three.
// RULE20 - Legacy base bit 0 reads one, bit 1 reads zero.
// RULE21 - Index and data ports also sit at fixed 3E0h and 3E1h.
// RULE22 - IO window base decodes bits 15 to 12, so windows are 4 KB minimum.
// RULE23 - Forward PCI IO inside base..limit inclusive, subject to alias blocking.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module cbr_config_regs
    import cbr_pkg::*;
#(
    parameter int ADDR_W = 9,
    parameter bit SOCKET_B = 1'b0
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    // AXI4-Lite write response
    output logic [1:0] AXI_BRESP_OUT,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    // IO transaction decode
    input wire logic IO_REQ_IN,
    input wire logic [31:0] IO_ADDR_IN,
    input wire logic IO_FROM_CARD_IN,
    output logic IO_FORWARD_OUT,
    output logic IO_BLOCKED_OUT,
    output logic LEGACY_INDEX_SEL_OUT,
    output logic LEGACY_DATA_SEL_OUT,
    output logic LEGACY_BAD_OUT,
    // Master abort handling
    input wire logic MABORT_IN,
    input wire logic MABORT_POSTED_DONE_IN,
    input wire logic CMD_SERR_EN_IN,
    output logic MABORT_ALL_ONES_OUT,
    output logic MABORT_TARGET_ABORT_OUT,
    // Card side errors and reset
    input wire logic CARD_SERR_IN,
    input wire logic CARD_PERR_IN,
    output logic PCI_SERR_OUT,
    output logic PARITY_REPORT_OUT,
    output logic CARD_RESET_OUT
);

    generate
        if (ADDR_W < MIN_ADDR_W) begin : g_chk
            $error("ADDR_W too narrow for the register map");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = a >> 2;
        return w[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Bus slave and register state.

    logic aw_held_q, aw_held_d;
    logic [7:0] aw_idx_q, aw_idx_d;
    logic w_held_q, w_held_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    logic [15:0] io_window1_base_lower_q, io_window1_base_lower_d;
    logic [15:0] io_window1_base_upper_q, io_window1_base_upper_d;
    logic [15:0] io_window1_limit_lower_q, io_window1_limit_lower_d;
    logic [7:0] irq_line_level_q, irq_line_level_d;
    logic [15:0] bridge_control_q, bridge_control_d;
    logic [31:0] legacy_port_base_q, legacy_port_base_d;

    logic [7:0] irq_pin_select;
    logic [15:0] bridge_control_rd;
    logic [31:0] legacy_port_base_rd;

    assign irq_pin_select = SOCKET_B ? IRQ_PIN_SOCKET_B : IRQ_PIN_SOCKET_A; // RULE5
    assign bridge_control_rd = (bridge_control_q & BC_WRITE_MASK) | BC_FIXED_ONES; // RULE6 RULE7
    assign legacy_port_base_rd = (legacy_port_base_q & LEG_BASE_MASK) | LEG_IO_SPACE; // RULE20

    always_comb begin
        logic [7:0] ridx;
        logic hit;
        ridx = word_index(AXI_ARADDR_IN);
        hit = 1'b0;
        aw_held_d = aw_held_q;
        aw_idx_d = aw_idx_q;
        w_held_d = w_held_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        io_window1_base_lower_d = io_window1_base_lower_q;
        io_window1_base_upper_d = io_window1_base_upper_q;
        io_window1_limit_lower_d = io_window1_limit_lower_q;
        irq_line_level_d = irq_line_level_q;
        bridge_control_d = bridge_control_q;
        legacy_port_base_d = legacy_port_base_q;

        if (bvalid_q && AXI_BREADY_IN) begin
            bvalid_d = 1'b0;
        end
        if (AXI_AWVALID_IN && awready_q) begin
            aw_held_d = 1'b1;
            aw_idx_d = word_index(AXI_AWADDR_IN);
        end
        if (AXI_WVALID_IN && wready_q) begin
            w_held_d = 1'b1;
            wdata_d = AXI_WDATA_IN;
            wstrb_d = AXI_WSTRB_IN;
        end
        // Writes are executed one cycle after both halves are held, so each path is one flop deep.
        if (aw_held_q && w_held_q && !bvalid_q) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            unique case (aw_idx_q)
                IDX_IO1_BASE_LOWER: begin
                    io_window1_base_lower_d =
                        16'(merge_bytes({16'h0000, io_window1_base_lower_q}, wdata_q, wstrb_q))
                        & IO_BASE_LOWER_MASK;
                end
                IDX_IO1_BASE_UPPER: begin
                    io_window1_base_upper_d =
                        16'(merge_bytes({16'h0000, io_window1_base_upper_q}, wdata_q,
                        wstrb_q)); // RULE1
                end
                IDX_IO1_LIMIT_LOWER: begin
                    io_window1_limit_lower_d =
                        16'(merge_bytes({16'h0000, io_window1_limit_lower_q}, wdata_q,
                        wstrb_q));
                end
                IDX_IRQ_LINE: begin
                    irq_line_level_d =
                        8'(merge_bytes({24'h00_0000, irq_line_level_q}, wdata_q,
                        wstrb_q)); // RULE4
                end
                IDX_BRIDGE_CTRL: begin
                    bridge_control_d =
                        16'(merge_bytes({16'h0000, bridge_control_q}, wdata_q, wstrb_q))
                        & BC_WRITE_MASK;
                end
                IDX_LEGACY_BASE: begin
                    legacy_port_base_d =
                        merge_bytes(legacy_port_base_q, wdata_q, wstrb_q)
                        & LEG_BASE_MASK; // RULE17
                end
                IDX_IO1_LIMIT_UPPER, IDX_IRQ_PIN, IDX_BOARD_MAKER, IDX_BOARD_VARIANT: begin
                    bresp_d = RESP_OKAY;
                end
                default: begin
                    bresp_d = RESP_SLVERR;
                end
            endcase
        end

        if (rvalid_q && AXI_RREADY_IN) begin
            rvalid_d = 1'b0;
        end
        if (AXI_ARVALID_IN && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = 32'h0000_0000;
            hit = 1'b1;
            unique case (ridx)
                IDX_IO1_BASE_LOWER: rdata_d = {16'h0000, io_window1_base_lower_q};
                IDX_IO1_BASE_UPPER: rdata_d = {16'h0000, io_window1_base_upper_q};
                IDX_IO1_LIMIT_LOWER: rdata_d = {16'h0000, io_window1_limit_lower_q};
                IDX_IO1_LIMIT_UPPER: rdata_d = 32'h0000_0000; // RULE3
                IDX_IRQ_LINE: rdata_d = {24'h00_0000, irq_line_level_q};
                IDX_IRQ_PIN: rdata_d = {24'h00_0000, irq_pin_select}; // RULE5
                IDX_BRIDGE_CTRL: rdata_d = {16'h0000, bridge_control_rd}; // RULE6
                IDX_BOARD_MAKER, IDX_BOARD_VARIANT: rdata_d = 32'h0000_0000; // RULE16
                IDX_LEGACY_BASE: rdata_d = legacy_port_base_rd; // RULE20
                default: hit = 1'b0;
            endcase
            rresp_d = hit ? RESP_OKAY : RESP_SLVERR;
        end

        awready_d = !aw_held_d && !bvalid_d;
        wready_d = !w_held_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            aw_held_q <= 1'b0;
            aw_idx_q <= 8'h00;
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            io_window1_base_lower_q <= RST_IO1_BASE_LOWER;
            io_window1_base_upper_q <= RST_IO1_BASE_UPPER; // RULE1
            io_window1_limit_lower_q <= RST_IO1_LIMIT_LOWER;
            irq_line_level_q <= RST_IRQ_LINE; // RULE4
            bridge_control_q <= RST_BRIDGE_CTRL & BC_WRITE_MASK; // RULE8
            legacy_port_base_q <= RST_LEGACY_BASE;
        end else begin
            aw_held_q <= aw_held_d;
            aw_idx_q <= aw_idx_d;
            w_held_q <= w_held_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            io_window1_base_lower_q <= io_window1_base_lower_d;
            io_window1_base_upper_q <= io_window1_base_upper_d;
            io_window1_limit_lower_q <= io_window1_limit_lower_d;
            irq_line_level_q <= irq_line_level_d;
            bridge_control_q <= bridge_control_d;
            legacy_port_base_q <= legacy_port_base_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Decode and error forwarding; every result is a registered one-cycle pulse or a level.

    logic fwd_q, fwd_d;
    logic blk_q, blk_d;
    logic idx_sel_q, idx_sel_d;
    logic dat_sel_q, dat_sel_d;
    logic bad_q, bad_d;
    logic ones_q, ones_d;
    logic tabort_q, tabort_d;
    logic serr_q, serr_d;
    logic perr_q, perr_d;
    logic card_reset_out_q, card_reset_out_d;

    always_comb begin
        logic in_win;
        logic alias_hit;
        logic pci_side;
        logic [31:0] leg;
        leg = legacy_port_base_q & LEG_BASE_MASK;
        pci_side = IO_REQ_IN && !IO_FROM_CARD_IN;
        // Below bit 16 only bits 15:12 take part, which is why no window is smaller than 4 KB.
        in_win = (IO_ADDR_IN[31:16] == io_window1_base_upper_q)
                 && (IO_ADDR_IN[15:12] >= io_window1_base_lower_q[15:12]) // RULE22
                 && (IO_ADDR_IN[15:12] <= io_window1_limit_lower_q[15:12]); // RULE2 RULE23
        alias_hit = bridge_control_q[BC_ALIAS_BLOCK] && (IO_ADDR_IN[31:16] == 16'h0000)
                    && (IO_ADDR_IN[9:8] != 2'b00); // RULE12
        fwd_d = 1'b0;
        blk_d = 1'b0;
        if (IO_REQ_IN && in_win) begin
            if (IO_FROM_CARD_IN) begin
                fwd_d = 1'b1; // RULE13
            end else if (alias_hit) begin
                blk_d = 1'b1; // RULE12
            end else begin
                fwd_d = 1'b1; // RULE23
            end
        end
        idx_sel_d = pci_side && ((IO_ADDR_IN == leg) || (IO_ADDR_IN == LEG_FIXED_INDEX)); // RULE18 RULE21
        dat_sel_d = pci_side && ((IO_ADDR_IN == leg + LEG_DATA_OFS)
                                 || (IO_ADDR_IN == LEG_FIXED_INDEX + LEG_DATA_OFS)); // RULE18 RULE21
        // Flagged but not answered; the host is expected never to go here.
        bad_d = pci_side && ((IO_ADDR_IN == leg + LEG_BAD2_OFS)
                             || (IO_ADDR_IN == leg + LEG_BAD3_OFS)); // RULE19
        ones_d = MABORT_IN && !bridge_control_q[BC_MABORT_MODE]; // RULE9
        tabort_d = MABORT_IN && bridge_control_q[BC_MABORT_MODE] && !MABORT_POSTED_DONE_IN; // RULE10
        serr_d = (MABORT_IN && bridge_control_q[BC_MABORT_MODE] && MABORT_POSTED_DONE_IN
                  && CMD_SERR_EN_IN) // RULE11
                 || (CARD_SERR_IN && bridge_control_q[BC_SERR_EN]); // RULE14
        perr_d = CARD_PERR_IN && bridge_control_q[BC_PARITY_EN]; // RULE15
        card_reset_out_d = bridge_control_q[BC_CARD_RESET]; // RULE8
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            fwd_q <= 1'b0;
            blk_q <= 1'b0;
            idx_sel_q <= 1'b0;
            dat_sel_q <= 1'b0;
            bad_q <= 1'b0;
            ones_q <= 1'b0;
            tabort_q <= 1'b0;
            serr_q <= 1'b0;
            perr_q <= 1'b0;
            card_reset_out_q <= 1'b1;
        end else begin
            fwd_q <= fwd_d;
            blk_q <= blk_d;
            idx_sel_q <= idx_sel_d;
            dat_sel_q <= dat_sel_d;
            bad_q <= bad_d;
            ones_q <= ones_d;
            tabort_q <= tabort_d;
            serr_q <= serr_d;
            perr_q <= perr_d;
            card_reset_out_q <= card_reset_out_d;
        end
    end

    assign AXI_AWREADY_OUT = awready_q;
    assign AXI_WREADY_OUT = wready_q;
    assign AXI_BRESP_OUT = bresp_q;
    assign AXI_BVALID_OUT = bvalid_q;
    assign AXI_ARREADY_OUT = arready_q;
    assign AXI_RDATA_OUT = rdata_q;
    assign AXI_RRESP_OUT = rresp_q;
    assign AXI_RVALID_OUT = rvalid_q;
    assign IO_FORWARD_OUT = fwd_q;
    assign IO_BLOCKED_OUT = blk_q;
    assign LEGACY_INDEX_SEL_OUT = idx_sel_q;
    assign LEGACY_DATA_SEL_OUT = dat_sel_q;
    assign LEGACY_BAD_OUT = bad_q;
    assign MABORT_ALL_ONES_OUT = ones_q;
    assign MABORT_TARGET_ABORT_OUT = tabort_q;
    assign PCI_SERR_OUT = serr_q;
    assign PARITY_REPORT_OUT = perr_q;
    assign CARD_RESET_OUT = card_reset_out_q;

endmodule

// *** cbr_config_props.sv ***
// Checker of the bridge config bank behaviour at its ports.
`timescale 1ns/1ns
module cbr_config_props (
    // Clock and reset
    input wire logic CLK_IN, NRST_IN,
    // Register bus handshakes
    input wire logic AXI_AWVALID_IN, AXI_AWREADY_OUT, AXI_WVALID_IN, AXI_WREADY_OUT,
    input wire logic AXI_BVALID_OUT, AXI_ARVALID_IN, AXI_ARREADY_OUT, AXI_RVALID_OUT,
    // IO decode
    input wire logic IO_REQ_IN, IO_FROM_CARD_IN, IO_FORWARD_OUT, IO_BLOCKED_OUT,
    input wire logic [31:0] IO_ADDR_IN,
    input wire logic LEGACY_INDEX_SEL_OUT, LEGACY_DATA_SEL_OUT,
    // Errors and card reset
    input wire logic MABORT_IN, MABORT_POSTED_DONE_IN, CMD_SERR_EN_IN,
    input wire logic MABORT_ALL_ONES_OUT, MABORT_TARGET_ABORT_OUT, CARD_SERR_IN, CARD_PERR_IN,
    input wire logic PCI_SERR_OUT, PARITY_REPORT_OUT, CARD_RESET_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    sequence wr_taken;
        AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
    endsequence
    sequence rd_taken;
        AXI_ARVALID_IN && AXI_ARREADY_OUT;
    endsequence
    logic pci_io;
    assign pci_io = IO_REQ_IN && !IO_FROM_CARD_IN;
    ////////////////////////////////////////////////////////////////////////////
    wr_answer_a: assert property (wr_taken |=> ##1 AXI_BVALID_OUT) else $error("late bvalid");
    rd_answer_a: assert property (rd_taken |=> AXI_RVALID_OUT) else $error("late rvalid");
    ar_refuse_a: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT) else $error("ar early");
    reset_card_a: assert property ($rose(NRST_IN) |-> CARD_RESET_OUT)
        else $error("card not held in reset");
    par_gate_a: assert property (PARITY_REPORT_OUT |-> $past(CARD_PERR_IN))
        else $error("parity report without cause");
    serr_cause_a: assert property (PCI_SERR_OUT |-> $past(CARD_SERR_IN ||
        MABORT_IN && MABORT_POSTED_DONE_IN && CMD_SERR_EN_IN)) else $error("serr without cause");
    mab_answer_a: assert property (MABORT_IN && !MABORT_POSTED_DONE_IN |=>
        MABORT_ALL_ONES_OUT ^ MABORT_TARGET_ABORT_OUT) else $error("abort not answered");
    ta_cause_a: assert property (MABORT_TARGET_ABORT_OUT |->
        $past(MABORT_IN && !MABORT_POSTED_DONE_IN)) else $error("target abort without cause");
    ones_cause_a: assert property (MABORT_ALL_ONES_OUT |-> $past(MABORT_IN))
        else $error("all ones without abort");
    card_side_a: assert property (IO_REQ_IN && IO_FROM_CARD_IN |=> !IO_BLOCKED_OUT &&
        !LEGACY_INDEX_SEL_OUT && !LEGACY_DATA_SEL_OUT) else $error("card io mishandled");
    fixed_ports_a: assert property (pci_io && IO_ADDR_IN[31:1] == 31'h0000_01F0 |=>
        ($past(IO_ADDR_IN[0]) ? LEGACY_DATA_SEL_OUT : LEGACY_INDEX_SEL_OUT))
        else $error("fixed port missed");
    alias_gate_a: assert property (IO_BLOCKED_OUT |-> $past(pci_io &&
        IO_ADDR_IN[31:16] == 16'h0000 && IO_ADDR_IN[9:8] != 2'h0)) else $error("bad block");
    fwd_cause_a: assert property (IO_FORWARD_OUT || IO_BLOCKED_OUT |->
        $past(IO_REQ_IN) && !(IO_FORWARD_OUT && IO_BLOCKED_OUT)) else $error("bad forward");
endmodule
bind cbr_config_regs cbr_config_props u_props (.*);

// *** cbr_card_model.sv ***
// Behavioural card on the secondary side that raises error events on command.
`timescale 1ns/1ns
module cbr_card_model (
    // Commands from the bench
    input wire logic serr_req_in,
    input wire logic perr_req_in,
    // Card pins
    input wire logic card_reset_in,
    output logic card_serr_out,
    output logic card_perr_out
);
    // A card held in reset cannot signal, so its events are lost then.
    assign card_serr_out = serr_req_in && !card_reset_in;
    assign card_perr_out = perr_req_in && !card_reset_in;
endmodule

// *** tb_top.sv ***
// Self-checking bench of the bridge config bank.
`timescale 1ns/1ns
module tb_top
    import cbr_pkg::*;
;
    logic clk, nrst, awv, wv, bry, arv, rry, ioreq, iocard, mab, posted, cmd, sreq, preq;
    logic awr, wrd, bv, arr, rvl, fwd, blk, lix, ldt, lbad, ao, ta, serr, par, card_reset_out, cse, cpe;
    logic [8:0] awa, ara;
    logic [31:0] wd, ioaddr, rdat, rv;
    logic [3:0] ws;
    logic [1:0] br, rr;
    logic [15:0] cur_bc;
    int mismatches, n_tests;
    localparam logic [7:0] IDX [9] = '{8'h36, 8'h38, 8'h3A, 8'h3C, 8'h3D, 8'h3E, 8'h40, 8'h42, 8'h44};
    localparam logic [31:0] RST [9] = '{0, 0, 0, 0, 1, 32'h0000_0340, 0, 0, 1};
    localparam logic [31:0] ONES [9] = '{32'h0000_FFFF, 32'h0000_FFFF, 0, 32'h0000_00FF, 1,
        32'h0000_0367, 0, 0, 32'hFFFF_F001};
    ////////////////////////////////////////////////////////////////////////////
    cbr_config_regs u_dut (.CLK_IN(clk), .NRST_IN(nrst),
        .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd),
        .AXI_WSTRB_IN(ws), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrd), .AXI_BRESP_OUT(br),
        .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bry), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv),
        .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rvl),
        .AXI_RREADY_IN(rry), .IO_REQ_IN(ioreq), .IO_ADDR_IN(ioaddr), .IO_FROM_CARD_IN(iocard),
        .IO_FORWARD_OUT(fwd), .IO_BLOCKED_OUT(blk), .LEGACY_INDEX_SEL_OUT(lix),
        .LEGACY_DATA_SEL_OUT(ldt), .LEGACY_BAD_OUT(lbad), .MABORT_IN(mab),
        .MABORT_POSTED_DONE_IN(posted), .CMD_SERR_EN_IN(cmd), .MABORT_ALL_ONES_OUT(ao),
        .MABORT_TARGET_ABORT_OUT(ta), .CARD_SERR_IN(cse), .CARD_PERR_IN(cpe),
        .PCI_SERR_OUT(serr), .PARITY_REPORT_OUT(par), .CARD_RESET_OUT(card_reset_out));
    cbr_card_model u_card (.serr_req_in(sreq), .perr_req_in(preq), .card_reset_in(card_reset_out),
        .card_serr_out(cse), .card_perr_out(cpe));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Ready lines stay high throughout, so the tasks never touch them.
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        awa <= 9'({idx, 2'h0});
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (!bv);
        check(32'(br), 32'(er));
    endtask
    task automatic rd(input logic [7:0] idx, input logic [1:0] er, output logic [31:0] d);
        ara <= 9'({idx, 2'h0});
        arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!rvl);
        d = rdat;
        check(32'(rr), 32'(er));
    endtask
    task automatic run(input logic [15:0] bc, input logic [31:0] a, input logic [6:0] in,
                       input logic [8:0] ex);
        if (bc !== cur_bc) begin
            wr(IDX_BRIDGE_CTRL, {16'h0000, bc}, 4'hF, RESP_OKAY);
            cur_bc = bc;
        end
        ioaddr <= a;
        {ioreq, iocard, mab, posted, cmd, sreq, preq} <= in;
        @(posedge clk);
        {ioreq, iocard, mab, posted, cmd, sreq, preq} <= 7'h00;
        @(posedge clk);
        check(32'({fwd, blk, lix, ldt, lbad, ao, ta, serr, par}), 32'(ex));
        check(32'(card_reset_out), 32'(bc[6]));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #50000;
        mismatches++;
        results();
    end
    initial begin
        {awv, wv, arv, ioreq, iocard, mab, posted, cmd, sreq, preq} = '0;
        {awa, ara, wd, ws, ioaddr} = '0;
        {bry, rry, nrst} = 3'h6;
        {mismatches, n_tests} = '0;
        cur_bc = 16'hFFFF;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check(32'(card_reset_out), 32'h0000_0001);
        for (int i = 0; i < 9; i++) begin
            rd(IDX[i], RESP_OKAY, rv);
            check(rv, RST[i]);
        end
        for (int i = 0; i < 9; i++) begin
            wr(IDX[i], 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
            rd(IDX[i], RESP_OKAY, rv);
            check(rv, ONES[i]);
        end
        wr(8'h36, 32'h0000_0000, 4'h2, RESP_OKAY);
        rd(8'h36, RESP_OKAY, rv);
        check(rv, 32'h0000_00FF);
        wr(8'h50, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        rd(8'h50, RESP_SLVERR, rv);
        check(rv, 32'h0000_0000);
        wr(8'h34, 32'h0000_2000, 4'hF, RESP_OKAY);
        wr(8'h36, 32'h0000_0000, 4'hF, RESP_OKAY);
        wr(8'h38, 32'h0000_3FFF, 4'hF, RESP_OKAY);
        wr(8'h44, 32'h0001_2000, 4'hF, RESP_OKAY);
        rd(8'h44, RESP_OKAY, rv);
        check(rv, 32'h0001_2001);
        run(16'h0000, 32'h0000_1FFF, 7'h40, 9'h000);
        run(16'h0000, 32'h0000_2000, 7'h40, 9'h100);
        run(16'h0000, 32'h0000_3FFF, 7'h40, 9'h100);
        run(16'h0000, 32'h0000_4000, 7'h40, 9'h000);
        run(16'h0000, 32'h0001_2100, 7'h40, 9'h000);
        run(16'h0000, 32'h0000_2100, 7'h40, 9'h100);
        run(16'h0004, 32'h0000_2100, 7'h40, 9'h080);
        run(16'h0004, 32'h0000_2000, 7'h40, 9'h100);
        run(16'h0004, 32'h0000_2100, 7'h60, 9'h100);
        run(16'h0004, 32'h0001_2000, 7'h40, 9'h040);
        run(16'h0004, 32'h0001_2001, 7'h40, 9'h020);
        run(16'h0004, 32'h0001_2002, 7'h40, 9'h010);
        run(16'h0004, 32'h0001_2003, 7'h40, 9'h010);
        run(16'h0004, 32'h0000_03E0, 7'h40, 9'h040);
        run(16'h0004, 32'h0000_03E1, 7'h40, 9'h020);
        run(16'h0004, 32'h0001_2000, 7'h60, 9'h000);
        run(16'h0000, 32'h0000_0000, 7'h10, 9'h008);
        run(16'h0000, 32'h0000_0000, 7'h1C, 9'h008);
        run(16'h0000, 32'h0000_0000, 7'h02, 9'h000);
        run(16'h0000, 32'h0000_0000, 7'h01, 9'h000);
        run(16'h0020, 32'h0000_0000, 7'h10, 9'h004);
        run(16'h0020, 32'h0000_0000, 7'h1C, 9'h002);
        run(16'h0020, 32'h0000_0000, 7'h18, 9'h000);
        run(16'h0002, 32'h0000_0000, 7'h02, 9'h002);
        run(16'h0001, 32'h0000_0000, 7'h01, 9'h001);
        run(16'h0042, 32'h0000_0000, 7'h02, 9'h000);
        run(16'h0002, 32'h0000_0000, 7'h02, 9'h002);
        results();
    end
endmodule
